//--- dtu_defines.svh
// Widths, reset values and slice positions of the DSP transfer unit
`ifndef DTU_DEFINES_SVH
`define DTU_DEFINES_SVH
`define DTU_WORD_W 16
`define DTU_LONG_W 32
`define DTU_GUARD_W 8
`define DTU_FULL_W 40
`define DTU_SIGN_REP_W 24
`define DTU_REG_COUNT 10
`define DTU_IDX_W 4
`define DTU_WORD_SIGN 15
`define DTU_LONG_SIGN 31
`define DTU_GUARD_SIGN 7
`define DTU_UPPER_LSB 16
`define DTU_GUARD_LSB 32
`define DTU_REG_RST 40'h00_0000_0000
`define DTU_WORD_CLEAR 16'h0000
`define DTU_GUARD_CLEAR 8'h00
`define DTU_LADDR_RST 32'h0000_0000
`define DTU_XADDR_RST 16'h0000
`endif

//--- dtu_pkg.sv
// Types shared by the DSP transfer unit
package dtu_pkg;
	typedef enum logic [1:0] {KIND_NONE, KIND_PARALLEL, KIND_DOUBLE, KIND_SINGLE} dtu_kind_type;
	typedef enum logic [1:0] {XFER_NONE, XFER_LOAD, XFER_STORE} dtu_xfer_type;
	typedef enum logic [1:0] {
		LMOVE_NONE, MOVE_TO_MULT_ACC, MOVE_FROM_MULT_ACC
	} dtu_lmove_type;
	// The first ten values are the physical register file slots
	typedef enum logic [3:0] {
		REG_ACCUMULATOR_FIRST, REG_ACCUMULATOR_SECOND,
		REG_MULT_INPUT_FIRST, REG_MULT_INPUT_SECOND,
		REG_X_INPUT_FIRST, REG_X_INPUT_SECOND,
		REG_Y_INPUT_FIRST, REG_Y_INPUT_SECOND,
		REG_MULT_ACC_LOW, REG_MULT_ACC_HIGH,
		REG_GUARD_FIRST, REG_GUARD_SECOND,
		REG_STATUS
	} dtu_reg_type;

	// Physical slot of a register name; guards map onto their accumulator
	function automatic logic [3:0] dtu_phys(input dtu_reg_type r);
		logic [3:0] idx;
		idx = 4'(r);
		if (r == REG_GUARD_FIRST) begin
			idx = 4'(REG_ACCUMULATOR_FIRST);
		end else if (r == REG_GUARD_SECOND) begin
			idx = 4'(REG_ACCUMULATOR_SECOND);
		end else if (r == REG_STATUS) begin
			idx = 4'(REG_ACCUMULATOR_FIRST);
		end
		return idx;
	endfunction
endpackage

//--- dtu_load_fmt.sv
// Formats a load word or longword into a 40-bit register image
`timescale 1ns/1ps
`include "dtu_defines.svh"
module dtu_load_fmt (
	input  wire logic                    long_in,
	input  wire logic                    guard_dst_in,
	input  wire logic                    has_guard_in,
	input  wire logic [`DTU_LONG_W-1:0]  data_in,
	input  wire logic [`DTU_FULL_W-1:0]  old_in,
	output logic      [`DTU_FULL_W-1:0]  value_out
);
	// Word to upper half with low half cleared, long fills both, sign into guard
	always_comb begin
		value_out = old_in;
		if (guard_dst_in) begin
			value_out = {data_in[`DTU_GUARD_W-1:0], old_in[`DTU_LONG_W-1:0]};
		end else if (long_in) begin
			value_out = {{`DTU_GUARD_W{data_in[`DTU_LONG_SIGN]}}, data_in};
		end else begin
			value_out = {{`DTU_GUARD_W{data_in[`DTU_WORD_SIGN]}},
				data_in[`DTU_WORD_W-1:0], `DTU_WORD_CLEAR};
		end
		// Registers without guard bits keep them clear
		if (!has_guard_in && !guard_dst_in) begin
			value_out[`DTU_FULL_W-1:`DTU_GUARD_LSB] = `DTU_GUARD_CLEAR;
		end
	end
endmodule

//--- dtu_stall.sv
// One-cycle overhead generator for hazards and bus resource conflicts
`timescale 1ns/1ps
module dtu_stall (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic conflict_in,
	output logic      stall_out
);
	typedef struct packed {
		logic paid;
	} dtu_stall_state_type;

	dtu_stall_state_type s_ff;
	dtu_stall_state_type nxt_s;

	// Stall once per conflicting line, then let it through
	always_comb begin
		nxt_s = s_ff;
		stall_out = conflict_in && !s_ff.paid;
		nxt_s.paid = stall_out;
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule

//--- dtu_transfer.sv
// DSP data transfer and local move path with conflict resolution
`timescale 1ns/1ps
`include "dtu_defines.svh"
module dtu_transfer (
	input  wire logic                        CLOCK_IN,
	input  wire logic                        RST_IN,
	input  wire logic                        ISSUE_IN,
	input  wire dtu_pkg::dtu_kind_type       KIND_IN,
	input  wire logic                        COND_OK_IN,
	input  wire dtu_pkg::dtu_xfer_type       X_OP_IN,
	input  wire logic                        X_SEL_IN,
	input  wire logic [`DTU_WORD_W-1:0]      X_ADDR_IN,
	input  wire dtu_pkg::dtu_xfer_type       Y_OP_IN,
	input  wire logic                        Y_SEL_IN,
	input  wire logic [`DTU_WORD_W-1:0]      Y_ADDR_IN,
	input  wire dtu_pkg::dtu_xfer_type       S_OP_IN,
	input  wire logic                        S_LONG_IN,
	input  wire dtu_pkg::dtu_reg_type        S_REG_IN,
	input  wire logic [`DTU_LONG_W-1:0]      S_ADDR_IN,
	input  wire dtu_pkg::dtu_lmove_type      LM_OP_IN,
	input  wire logic                        LM_HIGH_IN,
	input  wire logic                        LM_COND_IN,
	input  wire dtu_pkg::dtu_reg_type        LM_REG_IN,
	input  wire logic                        SYS_LOAD_IN,
	input  wire logic                        PROC_DEST_VALID_IN,
	input  wire dtu_pkg::dtu_reg_type        PROC_DEST_IN,
	input  wire logic                        ALU_WE_IN,
	input  wire logic                        ALU_CC_IN,
	input  wire dtu_pkg::dtu_reg_type        ALU_DEST_IN,
	input  wire logic [`DTU_FULL_W-1:0]      ALU_DATA_IN,
	input  wire logic                        MUL_WE_IN,
	input  wire dtu_pkg::dtu_reg_type        MUL_DEST_IN,
	input  wire logic [`DTU_FULL_W-1:0]      MUL_DATA_IN,
	input  wire dtu_pkg::dtu_reg_type        RD_REG_IN,
	input  wire logic [`DTU_WORD_W-1:0]      X_DATA_BUS_IN,
	input  wire logic [`DTU_WORD_W-1:0]      Y_DATA_BUS_IN,
	input  wire logic [`DTU_LONG_W-1:0]      LOCAL_DATA_BUS_IN,
	input  wire logic                        FETCH_REQ_IN,
	output logic      [`DTU_WORD_W-1:0]      X_ADDRESS_BUS_OUT,
	output logic                             X_RD_OUT,
	output logic                             X_WR_OUT,
	output logic      [`DTU_WORD_W-1:0]      X_DATA_BUS_OUT,
	output logic      [`DTU_WORD_W-1:0]      Y_ADDRESS_BUS_OUT,
	output logic                             Y_RD_OUT,
	output logic                             Y_WR_OUT,
	output logic      [`DTU_WORD_W-1:0]      Y_DATA_BUS_OUT,
	output logic      [`DTU_LONG_W-1:0]      LOCAL_ADDRESS_BUS_OUT,
	output logic                             LOCAL_RD_OUT,
	output logic                             LOCAL_WR_OUT,
	output logic                             LOCAL_LONG_OUT,
	output logic      [`DTU_LONG_W-1:0]      LOCAL_DATA_BUS_OUT,
	output logic                             FETCH_GRANT_OUT,
	output logic                             STALL_OUT,
	output logic                             CC_UPDATE_OUT,
	output logic      [`DTU_FULL_W-1:0]      RD_DATA_OUT
);
	localparam logic [3:0] IDX_ACC1 = 4'(dtu_pkg::REG_ACCUMULATOR_FIRST);
	localparam logic [3:0] IDX_ACC2 = 4'(dtu_pkg::REG_ACCUMULATOR_SECOND);
	localparam logic [3:0] IDX_X1 = 4'(dtu_pkg::REG_X_INPUT_FIRST);
	localparam logic [3:0] IDX_X2 = 4'(dtu_pkg::REG_X_INPUT_SECOND);
	localparam logic [3:0] IDX_Y1 = 4'(dtu_pkg::REG_Y_INPUT_FIRST);
	localparam logic [3:0] IDX_Y2 = 4'(dtu_pkg::REG_Y_INPUT_SECOND);
	localparam logic [3:0] IDX_MULT_ACC_LOW_REG = 4'(dtu_pkg::REG_MULT_ACC_LOW);
	localparam logic [3:0] IDX_MULT_ACC_HIGH_REG = 4'(dtu_pkg::REG_MULT_ACC_HIGH);

	typedef struct packed {
		logic [`DTU_REG_COUNT-1:0][`DTU_FULL_W-1:0] regs;
		logic                        px_v;
		logic                        px_sel;
		logic                        py_v;
		logic                        py_sel;
		logic                        ps_v;
		logic                        ps_long;
		dtu_pkg::dtu_reg_type        ps_reg;
		logic                        prev_v;
		logic [`DTU_IDX_W-1:0]       prev_idx;
		logic [`DTU_WORD_W-1:0]      x_addr;
		logic                        x_rd;
		logic                        x_wr;
		logic [`DTU_WORD_W-1:0]      x_wd;
		logic [`DTU_WORD_W-1:0]      y_addr;
		logic                        y_rd;
		logic                        y_wr;
		logic [`DTU_WORD_W-1:0]      y_wd;
		logic [`DTU_LONG_W-1:0]      l_addr;
		logic                        l_rd;
		logic                        l_wr;
		logic                        l_long;
		logic [`DTU_LONG_W-1:0]      l_wd;
		logic [`DTU_FULL_W-1:0]      rd_data;
	} dtu_state_type;

	dtu_state_type s_ff;
	dtu_state_type nxt_s;

	logic                    mem_kind;
	logic                    sgl_kind;
	logic                    x_load;
	logic                    x_store;
	logic                    y_load;
	logic                    y_store;
	logic                    s_load;
	logic                    s_store;
	logic                    s_legal;
	logic                    lm_go;
	logic                    lm_to;
	logic                    lm_from;
	logic                    haz_store;
	logic                    haz_lmove;
	logic                    haz_bus;
	logic                    conflict;
	logic                    stall;
	logic                    accept;
	logic [`DTU_IDX_W-1:0]   x_src_idx;
	logic [`DTU_IDX_W-1:0]   y_src_idx;
	logic [`DTU_IDX_W-1:0]   s_idx;
	logic [`DTU_IDX_W-1:0]   lm_idx;
	logic [`DTU_IDX_W-1:0]   alu_idx;
	logic [`DTU_IDX_W-1:0]   mul_idx;
	logic [`DTU_IDX_W-1:0]   px_idx;
	logic [`DTU_IDX_W-1:0]   py_idx;
	logic [`DTU_IDX_W-1:0]   ps_idx;
	logic                    s_guard;
	logic                    ps_guard;
	logic [`DTU_WORD_W-1:0]  x_st_data;
	logic [`DTU_WORD_W-1:0]  y_st_data;
	logic [`DTU_LONG_W-1:0]  s_st_data;
	logic [`DTU_FULL_W-1:0]  fx_val;
	logic [`DTU_FULL_W-1:0]  fy_val;
	logic [`DTU_FULL_W-1:0]  fs_val;
	logic [`DTU_FULL_W-1:0]  lm_src;

	// Decode of the presented line
	// parallel line carries processing plus both transfer slots
	// double line shares the X/Y slots and ignores conditions
	assign mem_kind = (KIND_IN == dtu_pkg::KIND_PARALLEL) || (KIND_IN == dtu_pkg::KIND_DOUBLE);
	assign sgl_kind = KIND_IN == dtu_pkg::KIND_SINGLE;
	// transfer strobes never look at COND_OK_IN
	assign x_load = ISSUE_IN && mem_kind && (X_OP_IN == dtu_pkg::XFER_LOAD);
	assign x_store = ISSUE_IN && mem_kind && (X_OP_IN == dtu_pkg::XFER_STORE);
	assign y_load = ISSUE_IN && mem_kind && (Y_OP_IN == dtu_pkg::XFER_LOAD);
	assign y_store = ISSUE_IN && mem_kind && (Y_OP_IN == dtu_pkg::XFER_STORE);
	// the status register is never a single-transfer operand
	assign s_legal = S_REG_IN != dtu_pkg::REG_STATUS;
	assign s_load = ISSUE_IN && sgl_kind && s_legal && (S_OP_IN == dtu_pkg::XFER_LOAD);
	assign s_store = ISSUE_IN && sgl_kind && s_legal && (S_OP_IN == dtu_pkg::XFER_STORE);
	assign lm_go = ISSUE_IN && (LM_OP_IN != dtu_pkg::LMOVE_NONE) &&
		(LM_REG_IN != dtu_pkg::REG_STATUS) && (!LM_COND_IN || COND_OK_IN);
	assign lm_to = lm_go && (LM_OP_IN == dtu_pkg::MOVE_TO_MULT_ACC);
	assign lm_from = lm_go && (LM_OP_IN == dtu_pkg::MOVE_FROM_MULT_ACC);

	// Register indices
	// parallel stores come only from the two accumulators
	assign x_src_idx = X_SEL_IN ? IDX_ACC2 : IDX_ACC1;
	assign y_src_idx = Y_SEL_IN ? IDX_ACC2 : IDX_ACC1;
	assign s_idx = dtu_pkg::dtu_phys(S_REG_IN);
	assign lm_idx = dtu_pkg::dtu_phys(LM_REG_IN);
	assign alu_idx = dtu_pkg::dtu_phys(ALU_DEST_IN);
	assign mul_idx = dtu_pkg::dtu_phys(MUL_DEST_IN);
	// X loads land in X inputs, Y loads in Y inputs
	assign px_idx = s_ff.px_sel ? IDX_X2 : IDX_X1;
	assign py_idx = s_ff.py_sel ? IDX_Y2 : IDX_Y1;
	assign ps_idx = dtu_pkg::dtu_phys(s_ff.ps_reg);
	assign s_guard = (S_REG_IN == dtu_pkg::REG_GUARD_FIRST) ||
		(S_REG_IN == dtu_pkg::REG_GUARD_SECOND);
	assign ps_guard = (s_ff.ps_reg == dtu_pkg::REG_GUARD_FIRST) ||
		(s_ff.ps_reg == dtu_pkg::REG_GUARD_SECOND);

	// Conflict detection feeding the one-cycle overhead
	// store source produced by the previous processing line
	assign haz_store = s_ff.prev_v && ((x_store && (x_src_idx == s_ff.prev_idx)) ||
		(y_store && (y_src_idx == s_ff.prev_idx)) || (s_store && (s_idx == s_ff.prev_idx)));
	// local move shares hardware with the X-side parallel move
	assign haz_lmove = lm_go && mem_kind && (X_OP_IN != dtu_pkg::XFER_NONE);
	// internal bus shared with the X-side load, regardless of operands
	assign haz_bus = (lm_to || (ISSUE_IN && SYS_LOAD_IN)) && x_load;
	assign conflict = haz_store || haz_lmove || haz_bus;

	dtu_stall u_stall (
		.clk_in      (CLOCK_IN),
		.rst_in      (RST_IN),
		.conflict_in (conflict),
		.stall_out   (stall)
	);

	assign accept = ISSUE_IN && !stall;
	assign STALL_OUT = stall;
	// the data transfer owns the local bus; fetch waits a cycle
	assign FETCH_GRANT_OUT = FETCH_REQ_IN && !(accept && (s_load || s_store));
	// only the processing unit may request a condition code update
	assign CC_UPDATE_OUT = ALU_WE_IN && ALU_CC_IN;

	// Store data selection
	// parallel stores move the upper word only
	assign x_st_data = s_ff.regs[x_src_idx][`DTU_LONG_W-1:`DTU_UPPER_LSB];
	assign y_st_data = s_ff.regs[y_src_idx][`DTU_LONG_W-1:`DTU_UPPER_LSB];
	always_comb begin
		s_st_data = {`DTU_WORD_CLEAR, s_ff.regs[s_idx][`DTU_LONG_W-1:`DTU_UPPER_LSB]};
		if (s_guard) begin
			// guard value sign-extended across the upper 24 bits
			s_st_data = {{`DTU_SIGN_REP_W{s_ff.regs[s_idx][`DTU_FULL_W-1]}},
				s_ff.regs[s_idx][`DTU_FULL_W-1:`DTU_GUARD_LSB]};
		end else if (S_LONG_IN) begin
			s_st_data = s_ff.regs[s_idx][`DTU_LONG_W-1:0];
		end
	end

	// Load formatters for the X, Y and local return paths
	// parallel loads are word loads into guardless registers
	dtu_load_fmt u_fmt_x (
		.long_in      (1'b0),
		.guard_dst_in (1'b0),
		.has_guard_in (1'b0),
		.data_in      ({`DTU_WORD_CLEAR, X_DATA_BUS_IN}),
		.old_in       (s_ff.regs[px_idx]),
		.value_out    (fx_val)
	);
	dtu_load_fmt u_fmt_y (
		.long_in      (1'b0),
		.guard_dst_in (1'b0),
		.has_guard_in (1'b0),
		.data_in      ({`DTU_WORD_CLEAR, Y_DATA_BUS_IN}),
		.old_in       (s_ff.regs[py_idx]),
		.value_out    (fy_val)
	);
	dtu_load_fmt u_fmt_s (
		.long_in      (s_ff.ps_long),
		.guard_dst_in (ps_guard),
		.has_guard_in ((ps_idx == IDX_ACC1) || (ps_idx == IDX_ACC2)),
		.data_in      (LOCAL_DATA_BUS_IN),
		.old_in       (s_ff.regs[ps_idx]),
		.value_out    (fs_val)
	);

	// Local move source: sign into guard only when an accumulator receives it
	always_comb begin
		lm_src = {`DTU_GUARD_CLEAR, s_ff.regs[LM_HIGH_IN ? IDX_MULT_ACC_HIGH_REG : IDX_MULT_ACC_LOW_REG][`DTU_LONG_W-1:0]};
		if ((lm_idx == IDX_ACC1) || (lm_idx == IDX_ACC2)) begin
			lm_src[`DTU_FULL_W-1:`DTU_GUARD_LSB] = {`DTU_GUARD_W{lm_src[`DTU_LONG_SIGN]}};
		end
	end

	// Next state: bus strobes, pending loads and ordered register writes
	always_comb begin
		nxt_s = s_ff;
		// X slot drives only X memory, Y slot only Y memory
		nxt_s.x_rd = accept && x_load;
		nxt_s.x_wr = accept && x_store;
		if (accept && (x_load || x_store)) begin
			nxt_s.x_addr = X_ADDR_IN;
		end
		if (accept && x_store) begin
			nxt_s.x_wd = x_st_data;
		end
		nxt_s.y_rd = accept && y_load;
		nxt_s.y_wr = accept && y_store;
		if (accept && (y_load || y_store)) begin
			nxt_s.y_addr = Y_ADDR_IN;
		end
		if (accept && y_store) begin
			nxt_s.y_wd = y_st_data;
		end
		// full 32-bit address from an X or extra pointer
		nxt_s.l_rd = accept && s_load;
		nxt_s.l_wr = accept && s_store;
		if (accept && (s_load || s_store)) begin
			nxt_s.l_addr = S_ADDR_IN;
			nxt_s.l_long = S_LONG_IN;
		end
		if (accept && s_store) begin
			nxt_s.l_wd = s_st_data;
		end
		// Loads complete one cycle after the strobe
		nxt_s.px_v = accept && x_load;
		nxt_s.py_v = accept && y_load;
		nxt_s.ps_v = accept && s_load;
		if (accept && x_load) begin
			nxt_s.px_sel = X_SEL_IN;
		end
		if (accept && y_load) begin
			nxt_s.py_sel = Y_SEL_IN;
		end
		if (accept && s_load) begin
			nxt_s.ps_long = S_LONG_IN;
			nxt_s.ps_reg = S_REG_IN;
		end
		// Producer of the line just accepted
		nxt_s.prev_v = accept && PROC_DEST_VALID_IN;
		nxt_s.prev_idx = dtu_pkg::dtu_phys(PROC_DEST_IN);
		// multiply dropped when the ALU names the same register
		if (MUL_WE_IN && !(ALU_WE_IN && (alu_idx == mul_idx))) begin
			nxt_s.regs[mul_idx] = MUL_DATA_IN;
		end
		if (accept && lm_to) begin
			nxt_s.regs[LM_HIGH_IN ? IDX_MULT_ACC_HIGH_REG : IDX_MULT_ACC_LOW_REG] =
				{`DTU_GUARD_CLEAR, s_ff.regs[lm_idx][`DTU_LONG_W-1:0]};
		end
		// copy out of a multiply-accumulate register
		if (accept && lm_from) begin
			nxt_s.regs[lm_idx] = lm_src;
		end
		// loads dropped when the ALU names the same register
		if (s_ff.px_v && !(ALU_WE_IN && (alu_idx == px_idx))) begin
			nxt_s.regs[px_idx] = fx_val;
		end
		if (s_ff.py_v && !(ALU_WE_IN && (alu_idx == py_idx))) begin
			nxt_s.regs[py_idx] = fy_val;
		end
		if (s_ff.ps_v && !(ALU_WE_IN && (alu_idx == ps_idx))) begin
			nxt_s.regs[ps_idx] = fs_val;
		end
		// ALU write has the last word
		if (ALU_WE_IN) begin
			nxt_s.regs[alu_idx] = ALU_DATA_IN;
		end
		nxt_s.rd_data = s_ff.regs[dtu_pkg::dtu_phys(RD_REG_IN)];
	end

	// State register
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Registered outputs
	assign X_ADDRESS_BUS_OUT = s_ff.x_addr;
	assign X_RD_OUT = s_ff.x_rd;
	assign X_WR_OUT = s_ff.x_wr;
	assign X_DATA_BUS_OUT = s_ff.x_wd;
	assign Y_ADDRESS_BUS_OUT = s_ff.y_addr;
	assign Y_RD_OUT = s_ff.y_rd;
	assign Y_WR_OUT = s_ff.y_wr;
	assign Y_DATA_BUS_OUT = s_ff.y_wd;
	assign LOCAL_ADDRESS_BUS_OUT = s_ff.l_addr;
	assign LOCAL_RD_OUT = s_ff.l_rd;
	assign LOCAL_WR_OUT = s_ff.l_wr;
	assign LOCAL_LONG_OUT = s_ff.l_long;
	assign LOCAL_DATA_BUS_OUT = s_ff.l_wd;
	assign RD_DATA_OUT = s_ff.rd_data;

	// Checks on the transfer path
	default clocking dtu_cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (RST_IN);

	stall_once_a: assert property (STALL_OUT |=> !STALL_OUT)
		else $error("overhead longer than one cycle");
	store_hazard_a: assert property (haz_store && !$past(STALL_OUT) |-> STALL_OUT)
		else $error("store after producer not stalled");
	bus_conflict_a: assert property (haz_bus && !$past(STALL_OUT) |-> STALL_OUT)
		else $error("shared bus conflict not stalled");
	x_store_a: assert property (accept && x_store |=> X_WR_OUT && !X_RD_OUT &&
		(X_DATA_BUS_OUT == $past(x_st_data)))
		else $error("X store data wrong");
	cond_free_a: assert property (accept && x_load && !COND_OK_IN |=> X_RD_OUT)
		else $error("condition suppressed a transfer");
	word_clear_a: assert property (s_ff.px_v && !ALU_WE_IN |=>
		s_ff.regs[$past(px_idx)][`DTU_WORD_W-1:0] == `DTU_WORD_CLEAR)
		else $error("word load left lower word");
	guard_store_a: assert property (accept && s_store && s_guard |=> LOCAL_WR_OUT &&
		(LOCAL_DATA_BUS_OUT[`DTU_LONG_W-1:`DTU_GUARD_W] ==
		{`DTU_SIGN_REP_W{LOCAL_DATA_BUS_OUT[`DTU_GUARD_SIGN]}}))
		else $error("guard store not sign extended");
	fetch_yield_a: assert property (accept && (s_load || s_store) |-> !FETCH_GRANT_OUT)
		else $error("fetch granted over data transfer");
	cc_quiet_a: assert property (CC_UPDATE_OUT |-> ALU_WE_IN)
		else $error("transfer touched condition codes");
	alu_wins_a: assert property (ALU_WE_IN && MUL_WE_IN && (alu_idx == mul_idx) |=>
		s_ff.regs[$past(alu_idx)] == $past(ALU_DATA_IN))
		else $error("multiply overrode ALU");
	load_drop_a: assert property (s_ff.ps_v && ALU_WE_IN && (alu_idx == ps_idx) |=>
		s_ff.regs[$past(alu_idx)] == $past(ALU_DATA_IN))
		else $error("load overrode ALU");
	long_load_a: assert property (s_ff.ps_v && s_ff.ps_long && !ps_guard && !ALU_WE_IN &&
		(ps_idx == IDX_ACC1) |=> s_ff.regs[IDX_ACC1] ==
		{{`DTU_GUARD_W{$past(LOCAL_DATA_BUS_IN[`DTU_LONG_SIGN])}}, $past(LOCAL_DATA_BUS_IN)})
		else $error("long load wrong");

	dual_xfer_c: cover property (accept && x_load && y_store);
	lmove_stall_c: cover property (haz_lmove ##1 accept);
	single_long_c: cover property (accept && s_load && S_LONG_IN ##1 LOCAL_RD_OUT);
	fetch_wait_c: cover property (FETCH_REQ_IN && !FETCH_GRANT_OUT);
endmodule

//--- dtu_mem_model.sv
// Behavioural X, Y and local memories facing the transfer unit
`timescale 1ns/1ps
module dtu_mem_model (
	input  wire logic        x_rd_in,
	input  wire logic        y_rd_in,
	input  wire logic        l_rd_in,
	input  wire logic [15:0] x_addr_in,
	input  wire logic [15:0] y_addr_in,
	input  wire logic [31:0] l_addr_in,
	output logic      [15:0] x_data_out,
	output logic      [15:0] y_data_out,
	output logic      [31:0] l_data_out
);
	// Address pattern while strobed, inverted while the bus is idle
	assign x_data_out = x_addr_in ^ 16'h5a5a ^ {16{!x_rd_in}};
	assign y_data_out = y_addr_in ^ 16'ha5a5 ^ {16{!y_rd_in}};
	assign l_data_out = l_addr_in ^ 32'h3c3c_c3c3 ^ {32{!l_rd_in}};
endmodule

//--- testbench.sv
// Self-checking bench for the DSP transfer unit
`timescale 1ns/1ps
module testbench;
	localparam dtu_pkg::dtu_reg_type  NOP = dtu_pkg::REG_STATUS;
	localparam dtu_pkg::dtu_xfer_type XN = dtu_pkg::XFER_NONE;
	logic        CLOCK_IN = 1'h0, RST_IN = 1'h1, ISSUE_IN, COND_OK_IN, X_SEL_IN, Y_SEL_IN;
	logic        S_LONG_IN, LM_HIGH_IN, LM_COND_IN, SYS_LOAD_IN, PROC_DEST_VALID_IN, ALU_WE_IN;
	logic        ALU_CC_IN, MUL_WE_IN, FETCH_REQ_IN, X_RD_OUT, X_WR_OUT, Y_RD_OUT, Y_WR_OUT;
	logic        LOCAL_RD_OUT, LOCAL_WR_OUT, LOCAL_LONG_OUT, FETCH_GRANT_OUT, STALL_OUT;
	logic        CC_UPDATE_OUT, rd_pend = 1'h0;
	logic [15:0] X_ADDR_IN, Y_ADDR_IN, X_DATA_BUS_IN, Y_DATA_BUS_IN, X_ADDRESS_BUS_OUT;
	logic [15:0] X_DATA_BUS_OUT, Y_ADDRESS_BUS_OUT, Y_DATA_BUS_OUT;
	logic [31:0] S_ADDR_IN, LOCAL_DATA_BUS_IN, LOCAL_ADDRESS_BUS_OUT, LOCAL_DATA_BUS_OUT;
	logic [39:0] ALU_DATA_IN, MUL_DATA_IN, RD_DATA_OUT, d, a, m, rq[$], sq[$], xq[$];
	dtu_pkg::dtu_kind_type  KIND_IN = dtu_pkg::KIND_NONE;
	dtu_pkg::dtu_xfer_type  X_OP_IN = XN, Y_OP_IN = XN, S_OP_IN = XN;
	dtu_pkg::dtu_lmove_type LM_OP_IN = dtu_pkg::LMOVE_NONE;
	dtu_pkg::dtu_reg_type   S_REG_IN = NOP, LM_REG_IN = NOP, PROC_DEST_IN = NOP;
	dtu_pkg::dtu_reg_type   RD_REG_IN = NOP, ALU_DEST_IN = NOP, MUL_DEST_IN = NOP;
	integer      seed = 32'hd2f7, mismatches = 0, n_checks = 0;
	dtu_transfer dtu_transfer_i (.*);
	dtu_mem_model dtu_mem_model_i (.x_rd_in(X_RD_OUT), .y_rd_in(Y_RD_OUT), .l_rd_in(LOCAL_RD_OUT),
		.x_addr_in(X_ADDRESS_BUS_OUT), .y_addr_in(Y_ADDRESS_BUS_OUT),
		.l_addr_in(LOCAL_ADDRESS_BUS_OUT), .x_data_out(X_DATA_BUS_IN),
		.y_data_out(Y_DATA_BUS_IN), .l_data_out(LOCAL_DATA_BUS_IN));
	task automatic cmp(input string what, input logic [39:0] exp, got);
		n_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic w(input integer n);
		repeat (n) @(negedge CLOCK_IN);
	endtask
	// Present the line, hold it until the edge that takes it, count stalled edges
	task automatic go(input integer ex);
		integer n;
		logic   st;
		n = 0;
		ISSUE_IN = 1'h1;
		do begin
			#5;
			st = STALL_OUT;
			n += st;
			if (KIND_IN == dtu_pkg::KIND_SINGLE && !st) begin
				cmp("grant", 40'h0, {39'h0, FETCH_GRANT_OUT});
			end
			@(negedge CLOCK_IN);
		end while (st === 1'h1 && n <= ex);
		cmp("stall", 40'(ex), 40'(n));
	endtask
	// Drop the line and every transfer request on it
	task automatic idle;
		{ISSUE_IN, SYS_LOAD_IN, PROC_DEST_VALID_IN} = 3'h0;
		X_OP_IN = XN;
		Y_OP_IN = XN;
		S_OP_IN = XN;
		LM_OP_IN = dtu_pkg::LMOVE_NONE;
	endtask
	// Note an expected register image for the monitor
	task automatic rd(input dtu_pkg::dtu_reg_type r, input logic [39:0] mk, e);
		RD_REG_IN = r;
		m = mk;
		rq.push_back(e & mk);
		rd_pend = 1'h1;
		@(negedge CLOCK_IN);
		rd_pend = 1'h0;
	endtask
	// Compare each result as it appears against the oldest note
	always @(posedge CLOCK_IN) begin
		#9;
		if (rd_pend) cmp("reg", rq.pop_front(), RD_DATA_OUT & m);
		if (LOCAL_WR_OUT) cmp("local", sq.pop_front(), {8'h00, LOCAL_DATA_BUS_OUT});
		if (X_WR_OUT) cmp("xstore", xq.pop_front(), {24'h0, X_DATA_BUS_OUT});
		if (Y_WR_OUT) cmp("ystore", xq.pop_front(), {24'h0, Y_DATA_BUS_OUT});
		if (!RST_IN) cmp("cc", {39'h0, ALU_WE_IN & ALU_CC_IN}, {39'h0, CC_UPDATE_OUT});
	end
	initial forever #10 CLOCK_IN = ~CLOCK_IN;
	// Watchdog against a hung run
	initial begin
		#40000;
		mismatches++;
		finish_test();
	end
	// Main sequence
	initial begin
		{ISSUE_IN, COND_OK_IN, X_SEL_IN, Y_SEL_IN, S_LONG_IN, LM_HIGH_IN, LM_COND_IN} = 7'h00;
		{SYS_LOAD_IN, PROC_DEST_VALID_IN, ALU_WE_IN, ALU_CC_IN, MUL_WE_IN, FETCH_REQ_IN} = 6'h01;
		{X_ADDR_IN, Y_ADDR_IN, S_ADDR_IN, ALU_DATA_IN, MUL_DATA_IN} = 144'h0;
		w(2);
		RST_IN = 1'h0;
		KIND_IN = dtu_pkg::KIND_PARALLEL;
		X_OP_IN = dtu_pkg::XFER_LOAD;
		Y_OP_IN = dtu_pkg::XFER_LOAD;
		{X_SEL_IN, Y_SEL_IN} = 2'h2;
		{X_ADDR_IN, Y_ADDR_IN} = $random(seed);
		d = {8'h00, X_ADDR_IN ^ 16'h5a5a, Y_ADDR_IN ^ 16'ha5a5};
		go(0);
		idle();
		w(2);
		rd(dtu_pkg::REG_X_INPUT_SECOND, 40'h00_ffff_ffff, {d[31:16], 16'h0000});
		rd(dtu_pkg::REG_Y_INPUT_FIRST, 40'h00_ffff_ffff, {d[15:0], 16'h0000});
		KIND_IN = dtu_pkg::KIND_SINGLE;
		for (int i = 0; i < 4; i++) begin
			S_OP_IN = dtu_pkg::XFER_LOAD;
			S_REG_IN = dtu_pkg::REG_ACCUMULATOR_FIRST;
			S_LONG_IN = i[0];
			S_ADDR_IN = $random(seed);
			d[31:0] = S_ADDR_IN ^ 32'h3c3c_c3c3;
			if (!i[0]) d[31:0] = {d[15:0], 16'h0000};
			d[39:32] = {8{d[31]}};
			go(0);
			idle();
			w(2);
			rd(dtu_pkg::REG_ACCUMULATOR_FIRST, 40'hff_ffff_ffff, d);
		end
		a = d;
		S_OP_IN = dtu_pkg::XFER_LOAD;
		S_REG_IN = dtu_pkg::REG_GUARD_SECOND;
		{S_LONG_IN, S_ADDR_IN} = {1'h0, $random(seed)};
		d[7:0] = S_ADDR_IN[7:0] ^ 8'hc3;
		go(0);
		idle();
		w(2);
		rd(dtu_pkg::REG_ACCUMULATOR_SECOND, 40'hff_0000_0000, {d[7:0], 32'h0});
		S_OP_IN = dtu_pkg::XFER_STORE;
		sq.push_back({8'h00, {24{d[7]}}, d[7:0]});
		go(0);
		idle();
		w(2);
		{ALU_WE_IN, ALU_CC_IN, MUL_WE_IN} = 3'h7;
		ALU_DEST_IN = dtu_pkg::REG_ACCUMULATOR_SECOND;
		MUL_DEST_IN = dtu_pkg::REG_ACCUMULATOR_SECOND;
		ALU_DATA_IN = 40'({$random(seed), $random(seed)});
		MUL_DATA_IN = ~ALU_DATA_IN;
		w(1);
		{ALU_WE_IN, ALU_CC_IN, MUL_WE_IN} = 3'h0;
		w(1);
		rd(dtu_pkg::REG_ACCUMULATOR_SECOND, 40'hff_ffff_ffff, ALU_DATA_IN);
		KIND_IN = dtu_pkg::KIND_PARALLEL;
		PROC_DEST_VALID_IN = 1'h1;
		PROC_DEST_IN = dtu_pkg::REG_ACCUMULATOR_FIRST;
		go(0);
		PROC_DEST_VALID_IN = 1'h0;
		X_SEL_IN = 1'h0;
		X_OP_IN = dtu_pkg::XFER_STORE;
		Y_OP_IN = dtu_pkg::XFER_STORE;
		xq.push_back({24'h0, a[31:16]});
		xq.push_back({24'h0, a[31:16]});
		go(1);
		X_OP_IN = dtu_pkg::XFER_LOAD;
		Y_OP_IN = XN;
		LM_OP_IN = dtu_pkg::MOVE_TO_MULT_ACC;
		LM_REG_IN = dtu_pkg::REG_ACCUMULATOR_FIRST;
		go(1);
		LM_OP_IN = dtu_pkg::LMOVE_NONE;
		SYS_LOAD_IN = 1'h1;
		go(1);
		X_OP_IN = XN;
		SYS_LOAD_IN = 1'h0;
		LM_OP_IN = dtu_pkg::MOVE_FROM_MULT_ACC;
		LM_REG_IN = dtu_pkg::REG_ACCUMULATOR_SECOND;
		go(0);
		idle();
		rd(dtu_pkg::REG_MULT_ACC_LOW, 40'hff_ffff_ffff, {8'h00, a[31:0]});
		rd(dtu_pkg::REG_ACCUMULATOR_SECOND, 40'hff_ffff_ffff, {{8{a[31]}}, a[31:0]});
		// Single load and ALU result meet on the same register
		KIND_IN = dtu_pkg::KIND_SINGLE;
		S_OP_IN = dtu_pkg::XFER_LOAD;
		S_REG_IN = dtu_pkg::REG_ACCUMULATOR_SECOND;
		go(0);
		ALU_WE_IN = 1'h1;
		idle();
		w(1);
		ALU_WE_IN = 1'h0;
		rd(dtu_pkg::REG_ACCUMULATOR_SECOND, 40'hff_ffff_ffff, ALU_DATA_IN);
		w(4);
		finish_test();
	end
endmodule
